// >>> rtl/pde_pkg.sv
// Shared constants and types for the presence-detect EEPROM link
// Function
// - Data line changes only while clock low
// - Master opens each command with start
// - Slave ignores bus until valid start
// - Stop ends transfer, slave enters standby
// - Receiver pulls data low on ninth clock
// - Acknowledge matching select byte after start
// - Acknowledge every byte once write selected; code acks data bytes only with write control low
// - Read: eight bits out, then sample acknowledge
// - Master acknowledge without stop: next byte
// - No acknowledge: release, await stop, standby
// - Select byte MSB first, bit0 one reads
// - Type 1010 plus strap bits selects array
// - Type 0110 plus strap bits selects protection
// - Current read returns byte at pointer
// - Random read: address write, restart, read
// - Sequential read continues while master acknowledges
// - Writes need write control low, 16 max
// - Ten ms program cycle, address unanswered
package pde_pkg;
  // ****************************************************
  // Select byte and memory layout
  // ****************************************************
  localparam logic [3:0] SEL_MEM_ID  = 4'ha;
  localparam logic [3:0] SEL_PROT_ID = 4'h6;
  localparam int         ADDR_W      = 8;
  localparam int         MEM_DEPTH   = 256;
  localparam int         PAGE_W      = 4;
  localparam logic [7:0] PROT_RST    = 8'h00;
  // Bit counter marks: 8 data bits, then the acknowledge clock
  localparam logic [3:0] CNT_ACK     = 4'h8;
  localparam logic [3:0] CNT_END     = 4'h9;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_KHZ     = 20000;
  localparam int WRC_TIME_US = 10000;
  localparam int WRC_CYCLES  = WRC_TIME_US * (CLK_KHZ / 1000);
  localparam int BUSY_W      = 18;
  localparam int SCL_KHZ     = 100;
  localparam int QTR_CYCLES  = CLK_KHZ / (SCL_KHZ * 4);
  localparam int DIV_W       = 6;
  // ****************************************************
  // Types
  // ****************************************************
  typedef enum logic [1:0] {
    CMD_START,
    CMD_STOP,
    CMD_WRITE,
    CMD_READ
  } pde_cmd_type;
endpackage : pde_pkg

// >>> rtl/pde_bus_if.sv
// Two-wire bus carrier with pull-up resolution of both ends
`timescale 1ns/10ps
interface pde_bus_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // Pull-ups win unless an enabled driver pulls low
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport dev (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe_n
  );
  modport host (
    input  scl,
    input  sda,
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n
  );
endinterface : pde_bus_if

// >>> rtl/pde_dev.sv
// Presence-detect EEPROM slave end of the two-wire link
`timescale 1ns/10ps
module pde_dev
  import pde_pkg::*;
#(
  parameter int unsigned WRC_CYCLES_P = WRC_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_strap_addr_bit0,
  input  wire logic i_strap_addr_bit1,
  input  wire logic i_strap_addr_bit2,
  input  wire logic i_write_control_pin,
  output logic      o_busy,
  output logic      o_standby,
  pde_bus_if.dev    bus
);

  // ****************************************************
  // Declarations
  // ****************************************************
  typedef enum logic [2:0] {
    DS_IDLE,
    DS_SEL,
    DS_ADDR,
    DS_WDATA,
    DS_RDATA,
    DS_WAIT
  } pde_dst_type;

  pde_dst_type       st_ff;
  logic [3:0]        cnt_ff;
  logic [7:0]        sh_ff;
  logic              drv_ff;
  logic [ADDR_W-1:0] ptr_ff;
  logic              prot_sel_ff;
  logic              rw_ff;
  logic              mack_ff;
  logic              wrote_ff;
  logic [BUSY_W-1:0] busy_ff;
  logic [7:0]        prot_ff;
  logic              scl_q_ff;
  logic              sda_q_ff;
  logic [7:0]        mem [MEM_DEPTH];

  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic [2:0]        strap;
  logic              sel_mem;
  logic              sel_prot;
  logic              wr_ok;
  logic              rx_ack;
  logic              byte_fall;
  logic              ack_fall;
  logic              mem_we;
  logic [7:0]        rd_byte;
  logic [ADDR_W-1:0] ptr_page;

  // ****************************************************
  // Line sampling and framing detection
  // ****************************************************
  // Previous samples; idle bus reads high on both lines
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= bus.scl;
      sda_q_ff <= bus.sda;
    end
  end

  // Data moving while clock high is framing, never data
  assign scl_rise  = bus.scl & ~scl_q_ff;
  assign scl_fall  = ~bus.scl & scl_q_ff;
  assign start_det = scl_q_ff & bus.scl & sda_q_ff & ~bus.sda;
  assign stop_det  = scl_q_ff & bus.scl & ~sda_q_ff & bus.sda;

  // ****************************************************
  // Select decode and acknowledge decision
  // ****************************************************
  assign strap    = {i_strap_addr_bit2, i_strap_addr_bit1,
                     i_strap_addr_bit0};
  // Bit0 of the select byte is the direction, read when set
  assign sel_mem  = (sh_ff[7:4] == SEL_MEM_ID) &&
                    (sh_ff[3:1] == strap);
  assign sel_prot = (sh_ff[7:4] == SEL_PROT_ID) &&
                    (sh_ff[3:1] == strap);
  // Write control low enables writes; reads ignore it
  assign wr_ok    = ~i_write_control_pin;

  // Select must match, address is always taken, data needs wr_ok
  always_comb begin
    unique case (st_ff)
      DS_SEL:   rx_ack = sel_mem | sel_prot;
      DS_ADDR:  rx_ack = 1'b1;
      DS_WDATA: rx_ack = wr_ok;
      default:  rx_ack = 1'b0;
    endcase
  end

  assign byte_fall = scl_fall && (cnt_ff == CNT_ACK);
  assign ack_fall  = scl_fall && (cnt_ff == CNT_END);
  assign mem_we    = (st_ff == DS_WDATA) && byte_fall && wr_ok;
  assign rd_byte   = prot_sel_ff ? prot_ff : mem[ptr_ff];
  // Page writes roll over inside the current 16-byte page
  assign ptr_page  = {ptr_ff[ADDR_W-1:PAGE_W],
                      ptr_ff[PAGE_W-1:0] + PAGE_W'(1)};

  // ****************************************************
  // Storage
  // ****************************************************
  // Array contents are data, so they are not reset
  always_ff @(posedge i_clk) begin
    if (mem_we && !prot_sel_ff) begin
      mem[ptr_ff] <= sh_ff;
    end
  end

  // Protection register written through its own select code
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prot_ff <= PROT_RST;
    end else if (mem_we && prot_sel_ff) begin
      prot_ff <= sh_ff;
    end
  end

  // ****************************************************
  // Program cycle timer
  // ****************************************************
  // Stop after a written byte starts the program cycle; the
  // timer models the worst case so a host never races it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_ff  <= '0;
      wrote_ff <= 1'b0;
    end else if (stop_det && wrote_ff) begin
      busy_ff  <= BUSY_W'(WRC_CYCLES_P);
      wrote_ff <= 1'b0;
    end else begin
      if (busy_ff != '0) begin
        busy_ff <= busy_ff - BUSY_W'(1);
      end
      if (mem_we) begin
        wrote_ff <= 1'b1;
      end
    end
  end

  // ****************************************************
  // Byte engine and transfer sequencing
  // ****************************************************
  // Framing has priority over bit activity; a start during
  // the program cycle is dropped so the address gets no ack
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff       <= DS_IDLE;
      cnt_ff      <= '0;
      sh_ff       <= '0;
      drv_ff      <= 1'b0;
      ptr_ff      <= '0;
      prot_sel_ff <= 1'b0;
      rw_ff       <= 1'b0;
      mack_ff     <= 1'b0;
    end else if (stop_det) begin
      st_ff  <= DS_IDLE;
      drv_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (start_det) begin
      st_ff  <= (busy_ff != '0) ? DS_IDLE : DS_SEL;
      drv_ff <= 1'b0;
      cnt_ff <= '0;
    end else begin
      unique case (st_ff)
        DS_IDLE, DS_WAIT: begin
          // Only framing wakes these states
          drv_ff <= 1'b0;
        end
        DS_SEL, DS_ADDR, DS_WDATA: begin
          if (scl_rise && (cnt_ff < CNT_ACK)) begin
            // Shift in on the rising clock, MSB first
            sh_ff  <= {sh_ff[6:0], bus.sda};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_fall) begin
            // Pull low across the whole ninth clock
            cnt_ff <= CNT_END;
            drv_ff <= rx_ack;
            if (!rx_ack) begin
              st_ff <= DS_WAIT;
            end
            if (st_ff == DS_SEL) begin
              prot_sel_ff <= sel_prot;
              rw_ff       <= sh_ff[0];
            end
            if (st_ff == DS_ADDR) begin
              ptr_ff <= sh_ff;
            end
            if (st_ff == DS_WDATA && wr_ok) begin
              ptr_ff <= ptr_page;
            end
          end else if (ack_fall) begin
            cnt_ff <= '0;
            if (st_ff == DS_SEL && rw_ff) begin
              // First read byte comes from the pointer as it is
              st_ff  <= DS_RDATA;
              sh_ff  <= rd_byte;
              drv_ff <= ~rd_byte[7];
              ptr_ff <= ptr_ff + ADDR_W'(1);
            end else begin
              drv_ff <= 1'b0;
              st_ff  <= (st_ff == DS_SEL) ? DS_ADDR : DS_WDATA;
            end
          end
        end
        DS_RDATA: begin
          if (scl_rise && (cnt_ff < CNT_ACK)) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_rise && (cnt_ff == CNT_ACK)) begin
            // Master's answer sampled on the ninth clock
            mack_ff <= ~bus.sda;
            cnt_ff  <= CNT_END;
          end else if (byte_fall) begin
            drv_ff <= 1'b0;
          end else if (scl_fall && (cnt_ff != '0) &&
                       (cnt_ff < CNT_ACK)) begin
            // New bit only while the clock is low
            sh_ff  <= {sh_ff[6:0], 1'b0};
            drv_ff <= ~sh_ff[6];
          end else if (ack_fall) begin
            cnt_ff <= '0;
            if (mack_ff) begin
              sh_ff  <= rd_byte;
              drv_ff <= ~rd_byte[7];
              ptr_ff <= ptr_ff + ADDR_W'(1);
            end else begin
              st_ff  <= DS_WAIT;
              drv_ff <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Open-drain: only ever pulls low, enable is active low
  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = ~drv_ff;
  assign o_busy           = (busy_ff != '0);
  assign o_standby        = (st_ff == DS_IDLE);

endmodule : pde_dev

// >>> rtl/pde_host.sv
// Two-wire bus master end driving the presence-detect link
`timescale 1ns/10ps
module pde_host
  import pde_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_cmd_valid,
  input  pde_cmd_type i_cmd,
  input  wire logic [7:0] i_wr_byte,
  input  wire logic  i_rd_ack,
  output logic       o_cmd_ready,
  output logic       o_done,
  output logic [7:0] o_rd_byte,
  output logic       o_ack_seen,
  pde_bus_if.host    bus
);

  // ****************************************************
  // Declarations
  // ****************************************************
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_START,
    HS_BIT,
    HS_STOP
  } pde_hst_type;

  pde_hst_type      st_ff;
  logic [DIV_W-1:0] div_ff;
  logic [1:0]       ph_ff;
  logic [3:0]       bit_ff;
  logic [8:0]       tx_ff;
  logic [8:0]       rx_ff;
  logic             scl_drv_ff;
  logic             sda_drv_ff;
  logic             tick;

  // ****************************************************
  // Quarter-period enable
  // ****************************************************
  // Four ticks per clock period keep every bus gap above minimum
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_ff <= '0;
    end else if (div_ff == DIV_W'(QTR_CYCLES - 1)) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end
  assign tick = (div_ff == DIV_W'(QTR_CYCLES - 1));

  // ****************************************************
  // Command sequencer
  // ****************************************************
  // Start, write and read end with the clock held low so the
  // next one may move the data line safely; stop releases it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_ff      <= HS_IDLE;
      ph_ff      <= '0;
      bit_ff     <= '0;
      tx_ff      <= '1;
      rx_ff      <= '0;
      scl_drv_ff <= 1'b0;
      sda_drv_ff <= 1'b0;
      o_done     <= 1'b0;
      o_rd_byte  <= '0;
      o_ack_seen <= 1'b0;
    end else begin
      o_done <= 1'b0;
      unique case (st_ff)
        HS_IDLE: begin
          if (i_cmd_valid) begin
            ph_ff  <= '0;
            bit_ff <= '0;
            unique case (i_cmd)
              CMD_START: st_ff <= HS_START;
              CMD_STOP:  st_ff <= HS_STOP;
              CMD_WRITE: begin
                // Byte MSB first, then release for the ack
                st_ff <= HS_BIT;
                tx_ff <= {i_wr_byte, 1'b1};
              end
              CMD_READ: begin
                st_ff <= HS_BIT;
                tx_ff <= {8'hff, ~i_rd_ack};
              end
            endcase
          end
        end
        HS_START: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            unique case (ph_ff)
              2'h0: sda_drv_ff <= 1'b0;
              2'h1: scl_drv_ff <= 1'b0;
              2'h2: sda_drv_ff <= 1'b1;
              2'h3: begin
                scl_drv_ff <= 1'b1;
                st_ff      <= HS_IDLE;
                o_done     <= 1'b1;
              end
            endcase
          end
        end
        HS_BIT: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            unique case (ph_ff)
              2'h0: sda_drv_ff <= ~tx_ff[8];
              2'h1: scl_drv_ff <= 1'b0;
              2'h2: rx_ff <= {rx_ff[7:0], bus.sda};
              2'h3: begin
                scl_drv_ff <= 1'b1;
                tx_ff      <= {tx_ff[7:0], 1'b1};
                if (bit_ff == CNT_ACK) begin
                  st_ff      <= HS_IDLE;
                  o_done     <= 1'b1;
                  o_rd_byte  <= rx_ff[8:1];
                  o_ack_seen <= ~rx_ff[0];
                end else begin
                  bit_ff <= bit_ff + 4'h1;
                end
              end
            endcase
          end
        end
        HS_STOP: begin
          if (tick) begin
            ph_ff <= ph_ff + 2'h1;
            unique case (ph_ff)
              2'h0: sda_drv_ff <= 1'b1;
              2'h1: scl_drv_ff <= 1'b0;
              2'h2: sda_drv_ff <= 1'b0;
              2'h3: begin
                st_ff  <= HS_IDLE;
                o_done <= 1'b1;
              end
            endcase
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign o_cmd_ready       = (st_ff == HS_IDLE);
  assign bus.host_scl_o    = 1'b0;
  assign bus.host_scl_oe_n = ~scl_drv_ff;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_sda_oe_n = ~sda_drv_ff;

endmodule : pde_host

// >>> sim/pde_assertions.sv
// Concurrent checks on the two-wire link between both ends
`timescale 1ns/10ps
module pde_assertions #(
  parameter int unsigned WRC_CYCLES_P = 50
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe_n,
  input wire logic o_busy,
  input wire logic o_standby
);
  // ****************************************************
  // Helper counters
  // ****************************************************
  logic [31:0] busy_cnt_ff;
  logic [15:0] drive_cnt_ff;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Length of the current program window
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !o_busy) begin
      busy_cnt_ff <= 32'h0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end
  end

  // Length of an unbroken device drive; a stuck driver would hang the bus
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || dev_sda_oe_n) begin
      drive_cnt_ff <= 16'h0;
    end else begin
      drive_cnt_ff <= drive_cnt_ff + 16'h1;
    end
  end

  // ****************************************************
  // Link properties
  // ****************************************************
  dev_change_low_a: assert property (
    $changed(dev_sda_oe_n) |-> !$past(scl))
    else $error("device moved data while clock high");
  dev_hold_high_a: assert property (
    $rose(scl) |=> $stable(dev_sda_oe_n)[*8])
    else $error("device bit not held over clock high");
  stop_standby_a: assert property (
    scl && $past(scl) && $rose(sda) |-> ##[1:3] (o_standby || o_busy))
    else $error("no standby after stop");
  idle_release_a: assert property (
    o_standby |-> dev_sda_oe_n)
    else $error("device drives while idle");
  busy_mute_a: assert property (
    o_busy |-> dev_sda_oe_n)
    else $error("device drives during program cycle");
  busy_len_a: assert property (
    $fell(o_busy) |-> busy_cnt_ff == WRC_CYCLES_P)
    else $error("program window has wrong length");
  busy_cause_a: assert property (
    $rose(o_busy) |-> scl && sda)
    else $error("program window opened without stop");
  // Longest legal drive: select ack plus a read byte of zeros,
  // nine bit times of four quarter ticks of 50 clocks each
  drive_bounded_a: assert property (
    drive_cnt_ff <= 16'h0708)
    else $error("device holds data past nine bit times");
endmodule : pde_assertions

// >>> sim/test_presence_detect_eeprom_slave.sv
// Self-checking bench joining host and device across the link
`timescale 1ns/10ps
module test_presence_detect_eeprom_slave;
  import pde_pkg::*;
  // ****************************************************
  // Signals
  // ****************************************************
  // Long enough that a start and select fall inside the window
  localparam int unsigned WRC_SIM = 3000;
  logic        i_clk     = 1'b0;
  logic        i_rst_n   = 1'b0;
  logic [2:0]  strap     = 3'h0;
  logic        wc        = 1'b0;
  logic        cmd_valid = 1'b0;
  pde_cmd_type cmd       = CMD_START;
  logic [7:0]  wr_byte   = 8'h00;
  logic        rd_ack    = 1'b0;
  logic        cmd_ready;
  logic        done;
  logic        ack_seen;
  logic        busy;
  logic        standby;
  logic [7:0]  rd_byte;
  logic [7:0]  base;
  logic [7:0]  d [4];
  int          n_fail     = 0;
  int          n_compared = 0;

  // 20 MHz clock
  always #25 i_clk = ~i_clk;

  pde_bus_if pde_bus_if_inst ();
  pde_dev #(.WRC_CYCLES_P(WRC_SIM)) pde_dev_inst (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .i_strap_addr_bit0   (strap[0]),
    .i_strap_addr_bit1   (strap[1]),
    .i_strap_addr_bit2   (strap[2]),
    .i_write_control_pin (wc),
    .o_busy              (busy),
    .o_standby           (standby),
    .bus                 (pde_bus_if_inst)
  );
  pde_host pde_host_inst (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_cmd_valid (cmd_valid),
    .i_cmd       (cmd),
    .i_wr_byte   (wr_byte),
    .i_rd_ack    (rd_ack),
    .o_cmd_ready (cmd_ready),
    .o_done      (done),
    .o_rd_byte   (rd_byte),
    .o_ack_seen  (ack_seen),
    .bus         (pde_bus_if_inst)
  );
  pde_assertions #(.WRC_CYCLES_P(WRC_SIM)) pde_assertions_inst (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .scl          (pde_bus_if_inst.scl),
    .sda          (pde_bus_if_inst.sda),
    .dev_sda_oe_n (pde_bus_if_inst.dev_sda_oe_n),
    .o_busy       (busy),
    .o_standby    (standby)
  );

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One host command; valid drops at the accepting edge
  task automatic xfer(input pde_cmd_type c, input logic [7:0] b,
                      input logic a);
    int k;
    @(posedge i_clk);
    cmd_valid <= 1'b1;
    cmd       <= c;
    wr_byte   <= b;
    rd_ack    <= a;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge i_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 2500);
    if (done !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t command never finished", $time);
    end else begin
      chk({7'h00, cmd_ready}, 8'h01);
    end
  endtask : xfer

  task automatic wr(input logic [7:0] b, input logic e);
    xfer(CMD_WRITE, b, 1'b0);
    chk({7'h00, ack_seen}, {7'h00, e});
  endtask : wr

  task automatic rd(input logic a, input logic [7:0] e);
    xfer(CMD_READ, 8'h00, a);
    chk(rd_byte, e);
  endtask : rd

  function automatic logic [7:0] sel(input logic [3:0] id, input logic rw);
    return {id, strap, rw};
  endfunction : sel

  // Address write, repeated start, then read select
  task automatic seek(input logic [7:0] a);
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b0), 1'b1);
    wr(a, 1'b1);
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b1), 1'b1);
  endtask : seek

  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ****************************************************
  // Sequence
  // ****************************************************
  // Watchdog sized well above the expected run of about 50k cycles
  initial begin
    repeat (90000) @(posedge i_clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    int k;
    void'($urandom(57));
    @(posedge i_clk);
    strap <= 3'($urandom);
    base = 8'($urandom) & 8'hf0;
    foreach (d[i]) d[i] = 8'($urandom);
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk({6'h00, standby, busy}, 8'h02);
    chk({6'h00, pde_bus_if_inst.scl, pde_bus_if_inst.sda}, 8'h03);
    // Protection register returns its reset value
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_PROT_ID, 1'b1), 1'b1);
    rd(1'b0, PROT_RST);
    xfer(CMD_STOP, 8'h00, 1'b0);
    // Foreign strap bits are not answered
    xfer(CMD_START, 8'h00, 1'b0);
    wr({SEL_MEM_ID, ~strap, 1'b0}, 1'b0);
    xfer(CMD_STOP, 8'h00, 1'b0);
    // Page write that crosses the page end wraps to its start
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b0), 1'b1);
    wr(base + 8'h0e, 1'b1);
    foreach (d[i]) wr(d[i], 1'b1);
    xfer(CMD_STOP, 8'h00, 1'b0);
    chk({7'h00, busy}, 8'h01);
    // Select during the program window gets no answer
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b1), 1'b0);
    xfer(CMD_STOP, 8'h00, 1'b0);
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk({7'h00, busy}, 8'h00);
    // Write control high blocks data bytes
    @(posedge i_clk);
    wc <= 1'b1;
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b0), 1'b1);
    xfer(CMD_WRITE, base + 8'h0e, 1'b0);
    wr(~d[0], 1'b0);
    xfer(CMD_STOP, 8'h00, 1'b0);
    repeat (4) @(posedge i_clk);
    #1;
    chk({7'h00, busy}, 8'h00);
    // Sequential read from the page end, reads work with write control high
    seek(base + 8'h0e);
    rd(1'b1, d[0]);
    rd(1'b0, d[1]);
    chk({7'h00, pde_bus_if_inst.dev_sda_oe_n}, 8'h01);
    xfer(CMD_STOP, 8'h00, 1'b0);
    @(posedge i_clk);
    wc <= 1'b0;
    seek(base);
    rd(1'b0, d[2]);
    xfer(CMD_STOP, 8'h00, 1'b0);
    // Current read continues from the advanced pointer
    xfer(CMD_START, 8'h00, 1'b0);
    wr(sel(SEL_MEM_ID, 1'b1), 1'b1);
    rd(1'b0, d[3]);
    xfer(CMD_STOP, 8'h00, 1'b0);
    chk({6'h00, standby, pde_bus_if_inst.sda}, 8'h03);
    print_verdict();
  end
endmodule : test_presence_detect_eeprom_slave
